// ===== src/sysbus_agent_end.sv
// External agent end: single-word writes, independent transfers closed
// by a release null, and read responses fed beat by beat by its user.
// Assumes the processor end runs on clock_in.
`timescale 1ns/1ps
module sysbus_agent_end
  import sysbus_pkg::*;
(
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               srst_in,
  // Operations
  input  wire logic               op_valid_in,
  input  wire logic               op_indep_in,
  input  wire logic [AD_W-1:0]    op_addr_in,
  input  wire logic [AD_W-1:0]    op_data_in,
  input  wire logic [7:0]         op_len_in,
  output logic                    op_ready_out,
  output logic                    op_done_out,
  // Pending processor read and its response beats
  output logic                    rd_pend_out,
  output logic      [AD_W-1:0]    rd_addr_out,
  output logic                    rd_block_out,
  output logic                    resp_ready_out,
  input  wire logic               resp_valid_in,
  input  wire logic [AD_W-1:0]    resp_data_in,
  input  wire logic               resp_error_in,
  // Bus
  sysbus_if.agent_end             bus
);

  typedef enum logic [2:0] {
    AG_IDLE  = 3'b000,
    AG_WAIT  = 3'b001,
    AG_GAP   = 3'b010,
    AG_ADDR  = 3'b011,
    AG_DATA  = 3'b100,
    AG_INDEP = 3'b101,
    AG_RGAP  = 3'b110,
    AG_RESP  = 3'b111
  } agent_state_type;

  agent_state_type  state_ff;
  logic             busy_ff;
  logic             indep_ff;
  logic [AD_W-1:0]  data_ff;
  logic [7:0]       len_ff;
  logic [3:0]       beat_ff;
  logic [CMD_W-1:0] cmd_ff;
  logic [AD_W-1:0]  ad_ff;
  logic             oe_n_ff;
  logic             valid_n_ff;
  logic             req_n_ff;
  logic             rd_seen;
  logic             resp_last;

  assign rd_seen = !bus.cpu_valid_n && !bus.command_bus[KIND_BIT] &&
                   bus.command_bus[7:5] == CMD_READ;
  assign resp_last = beat_ff == (rd_block_out ? BLOCK_BEATS - 4'h1 : 4'h0);

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_ff <= AG_IDLE;
      busy_ff <= 1'b0;
      indep_ff <= 1'b0;
      data_ff <= '0;
      len_ff <= 8'h0;
      beat_ff <= 4'h0;
      cmd_ff <= '1;
      ad_ff <= '1;
      oe_n_ff <= 1'b1;
      valid_n_ff <= 1'b1;
      req_n_ff <= 1'b1;
      op_ready_out <= 1'b0;
      op_done_out <= 1'b0;
      rd_pend_out <= 1'b0;
      rd_addr_out <= '0;
      rd_block_out <= 1'b0;
      resp_ready_out <= 1'b0;
    end else begin
      valid_n_ff <= 1'b1;
      op_done_out <= 1'b0;
      // Drops after a take until the agent is back in AG_IDLE; a user already waiting is not locked out
      op_ready_out <= state_ff == AG_IDLE && !busy_ff && !(op_valid_in && op_ready_out);
      if (rd_seen && !rd_pend_out) begin
        rd_pend_out <= 1'b1;
        rd_addr_out <= bus.addr_data_bus;
        rd_block_out <= bus.command_bus[4:3] == PROP_BLOCK;
        state_ff <= AG_RGAP;
      end else begin
        case (state_ff)
          AG_IDLE: begin
            if (op_valid_in && op_ready_out) begin
              busy_ff <= 1'b1;
              indep_ff <= op_indep_in;
              data_ff <= op_data_in;
              len_ff <= op_len_in;
              ad_ff <= op_addr_in;
              req_n_ff <= 1'b0;
              state_ff <= AG_WAIT;
            end
          end
          AG_WAIT: begin
            if (!bus.release_n) begin
              state_ff <= AG_GAP;
            end
          end
          AG_GAP: begin
            // Two cycles after release: drop the request; take the bus unless the transfer is independent
            req_n_ff <= 1'b1;
            if (indep_ff) begin
              state_ff <= AG_INDEP;
            end else begin
              oe_n_ff <= 1'b0;
              valid_n_ff <= 1'b0;
              cmd_ff <= make_cmd(CMD_WRITE, PROP_WORD, SIZE_WORD);
              state_ff <= AG_ADDR;
            end
          end
          AG_ADDR: begin
            // One word, so the one data cycle is the final one
            valid_n_ff <= 1'b0;
            cmd_ff <= make_id(1'b1, 1'b0, 1'b0);
            ad_ff <= data_ff;
            state_ff <= AG_DATA;
          end
          AG_DATA: begin
            oe_n_ff <= 1'b1;
            busy_ff <= 1'b0;
            op_done_out <= 1'b1;
            state_ff <= AG_IDLE;
          end
          AG_INDEP: begin
            // Third parties own the bus; the valid strobe stays high
            if (len_ff != 8'h0) begin
              len_ff <= len_ff - 8'h1;
            end else begin
              oe_n_ff <= 1'b0;
              valid_n_ff <= 1'b0;
              cmd_ff <= make_cmd(CMD_NULL, PROP_RELEASE, RSVD3);
              ad_ff <= '1;
              state_ff <= AG_DATA;
            end
          end
          AG_RGAP: begin
            // Processor floats this cycle before the agent drives
            state_ff <= AG_RESP;
            beat_ff <= 4'h0;
            oe_n_ff <= 1'b0;
            resp_ready_out <= 1'b1;
          end
          AG_RESP: begin
            // Pacing follows the user's valid; the block keeps full size
            if (resp_valid_in && resp_ready_out) begin
              valid_n_ff <= 1'b0;
              cmd_ff <= make_id(resp_last, 1'b1, resp_error_in);
              ad_ff <= resp_data_in;
              beat_ff <= beat_ff + 4'h1;
              resp_ready_out <= !resp_last;
              if (resp_last) begin
                rd_pend_out <= 1'b0;
              end
            end else if (!resp_ready_out) begin
              oe_n_ff <= 1'b1;
              state_ff <= busy_ff ? AG_WAIT : AG_IDLE;
            end
          end
          default: begin
            state_ff <= AG_IDLE;
          end
        endcase
      end
    end
  end

  assign bus.agent_cmd = cmd_ff;
  assign bus.agent_ad = ad_ff;
  assign bus.agent_adc = check_bits(ad_ff);
  assign bus.agent_cmdp = ^cmd_ff;
  assign bus.agent_oe_n = oe_n_ff;
  assign bus.agent_valid_n = valid_n_ff;
  assign bus.ext_request_n = req_n_ff;

endmodule

// ===== src/sysbus_cpu_end.sv
// Processor end of the system bus: issues its own requests in master
// state and accepts agent writes and read responses in slave state.
// Assumes the agent runs on clock_in; no synchronisers are needed.
`timescale 1ns/1ps
module sysbus_cpu_end
  import sysbus_pkg::*;
(
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               srst_in,
  // Register port
  input  wire logic [REG_AW-1:0]  reg_addr_in,
  input  wire logic [AD_W-1:0]    reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic      [AD_W-1:0]    reg_rdata_out,
  // Own requests
  input  wire logic               req_valid_in,
  input  wire logic               req_write_in,
  input  wire logic               req_block_in,
  input  wire logic [AD_W-1:0]    req_addr_in,
  input  wire logic [AD_W-1:0]    req_data_in,
  output logic                    req_ready_out,
  output logic                    data_take_out,
  // Read response
  output logic                    resp_valid_out,
  output logic      [AD_W-1:0]    resp_data_out,
  output logic                    resp_last_out,
  output logic                    bus_error_out,
  output logic                    line_dirty_out,
  // External write
  output logic                    ext_wr_valid_out,
  output logic      [AD_W-1:0]    ext_wr_addr_out,
  output logic      [AD_W-1:0]    ext_wr_data_out,
  // Bus
  sysbus_if.cpu_end               bus
);

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WRITE   = 3'b001,
    ST_READ    = 3'b010,
    ST_RELEASE = 3'b011,
    ST_SLAVE   = 3'b100,
    ST_TURN    = 3'b101
  } cpu_state_type;

  cpu_state_type    state_ff;
  logic [AD_W-1:0]  cfg_ff;
  logic [CMD_W-1:0] cmd_ff;
  logic [AD_W-1:0]  ad_ff;
  logic             oe_n_ff;
  logic             valid_n_ff;
  logic             release_n_ff;
  logic             take_ff;
  logic [1:0]       pace_ff;
  logic [3:0]       beat_ff;
  logic             blk_ff;
  logic             rd_pend_ff;
  logic             rd_blk_ff;
  logic             err_ff;
  logic             wr_pend_ff;
  logic             ext_req;
  logic             in_valid;
  logic             in_id;
  logic             in_final;
  logic             in_bad;
  logic             last_beat;
  logic [2:0]       in_type;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of agent cycles

  assign ext_req = !bus.ext_request_n;
  assign in_valid = !bus.agent_valid_n && state_ff == ST_SLAVE;
  assign in_id = bus.command_bus[KIND_BIT];
  assign in_type = bus.command_bus[7:5];
  assign in_final = !bus.command_bus[FINAL_BIT];
  // Checked cycles with bad check or parity bits count as error data
  assign in_bad = bus.command_bus[ERR_BIT] ||
                  (!bus.command_bus[NOCHK_BIT] &&
                   (bus.addr_data_check_bus != check_bits(bus.addr_data_bus) ||
                    bus.command_parity_bus != ^bus.command_bus));
  assign last_beat = beat_ff == (blk_ff ? BLOCK_BEATS - 4'h1 : 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cfg_ff <= CFG_RESET;
    end else if (reg_wr_in && reg_addr_in == CFG_ADDR) begin
      cfg_ff <= reg_wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in && reg_addr_in == CFG_ADDR) begin
      reg_rdata_out <= cfg_ff;
    end else if (reg_rd_in && reg_addr_in == STAT_ADDR) begin
      reg_rdata_out <= {59'h0, rd_pend_ff, state_ff, oe_n_ff};
    end else begin
      reg_rdata_out <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus ownership and own requests

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_ff <= ST_IDLE;
      cmd_ff <= '1;
      ad_ff <= '0;
      oe_n_ff <= 1'b1;
      valid_n_ff <= 1'b1;
      release_n_ff <= 1'b1;
      take_ff <= 1'b0;
      pace_ff <= 2'h0;
      beat_ff <= 4'h0;
      blk_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      rd_blk_ff <= 1'b0;
      req_ready_out <= 1'b0;
    end else begin
      valid_n_ff <= 1'b1;
      release_n_ff <= 1'b1;
      req_ready_out <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          oe_n_ff <= 1'b0;
          if (ext_req) begin
            state_ff <= ST_RELEASE;
            release_n_ff <= 1'b0;
          end else if (req_valid_in) begin
            req_ready_out <= 1'b1;
            ad_ff <= req_addr_in;
            valid_n_ff <= 1'b0;
            blk_ff <= req_block_in;
            beat_ff <= 4'h0;
            if (req_write_in) begin
              state_ff <= ST_WRITE;
              take_ff <= 1'b1;
              cmd_ff <= make_cmd(CMD_WRITE, req_block_in ? PROP_BLOCK : PROP_WORD,
                                 req_block_in ? SIZE_BLK8 : SIZE_WORD);
            end else begin
              state_ff <= ST_READ;
              rd_blk_ff <= req_block_in;
              cmd_ff <= make_cmd(CMD_READ, req_block_in ? PROP_BLOCK : PROP_WORD,
                                 req_block_in ? SIZE_BLK8 : SIZE_WORD);
            end
          end
        end
        ST_WRITE: begin
          if (take_ff) begin
            // At most one double word per cycle
            cmd_ff <= make_id(last_beat, 1'b0, 1'b0);
            ad_ff <= req_data_in;
            valid_n_ff <= 1'b0;
            beat_ff <= beat_ff + 4'h1;
            take_ff <= !last_beat && cfg_ff[CFG_FAST_BIT];
            pace_ff <= cfg_ff[CFG_FAST_BIT] ? 2'h0 : SLOW_GAP;
            if (last_beat) begin
              pace_ff <= 2'h0;
            end
          end else if (pace_ff != 2'h0) begin
            pace_ff <= pace_ff - 2'h1;
            take_ff <= pace_ff == 2'h1;
          end else begin
            // Request seen late in the write is served right after it
            cmd_ff <= '1;
            state_ff <= ext_req ? ST_RELEASE : ST_IDLE;
            release_n_ff <= !ext_req;
          end
        end
        ST_READ: begin
          // Automatic slave entry: no release pulse, float at once
          state_ff <= ST_SLAVE;
          rd_pend_ff <= 1'b1;
          oe_n_ff <= 1'b1;
        end
        ST_RELEASE: begin
          state_ff <= ST_SLAVE;
          oe_n_ff <= 1'b1;
        end
        ST_SLAVE: begin
          if (in_valid && !in_id && in_type == CMD_NULL) begin
            state_ff <= ST_TURN;
          end else if (in_valid && in_id && in_final && (rd_pend_ff || wr_pend_ff)) begin
            state_ff <= ST_TURN;
            rd_pend_ff <= rd_pend_ff && !bus.command_bus[RESP_BIT] ? 1'b0 : rd_pend_ff;
          end
        end
        ST_TURN: begin
          // Agent floats this cycle; drive again only after it
          state_ff <= ST_IDLE;
          oe_n_ff <= 1'b0;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Incoming data cycles

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wr_pend_ff <= 1'b0;
      err_ff <= 1'b0;
      resp_valid_out <= 1'b0;
      resp_data_out <= '0;
      resp_last_out <= 1'b0;
      bus_error_out <= 1'b0;
      line_dirty_out <= 1'b0;
      ext_wr_valid_out <= 1'b0;
      ext_wr_addr_out <= '0;
      ext_wr_data_out <= '0;
    end else begin
      resp_valid_out <= 1'b0;
      resp_last_out <= 1'b0;
      bus_error_out <= 1'b0;
      line_dirty_out <= 1'b0;
      ext_wr_valid_out <= 1'b0;
      if (in_valid && !in_id && in_type == CMD_WRITE) begin
        wr_pend_ff <= 1'b1;
        ext_wr_addr_out <= bus.addr_data_bus;
      end else if (in_valid && in_id && wr_pend_ff && bus.command_bus[RESP_BIT]) begin
        // Single word only; the one data cycle closes the write
        wr_pend_ff <= !in_final;
        ext_wr_valid_out <= in_final && !in_bad;
        ext_wr_data_out <= bus.addr_data_bus;
      end else if (in_valid && in_id && rd_pend_ff && !bus.command_bus[RESP_BIT]) begin
        resp_valid_out <= 1'b1;
        resp_data_out <= bus.addr_data_bus;
        resp_last_out <= in_final;
        err_ff <= in_final ? 1'b0 : (err_ff || in_bad);
        bus_error_out <= in_final && (err_ff || in_bad);
        line_dirty_out <= in_final && rd_blk_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; check and parity bits share the bus flops' timing

  assign bus.cpu_cmd = cmd_ff;
  assign bus.cpu_ad = ad_ff;
  assign bus.cpu_adc = check_bits(ad_ff);
  assign bus.cpu_cmdp = ^cmd_ff;
  assign bus.cpu_oe_n = oe_n_ff;
  assign bus.cpu_valid_n = valid_n_ff;
  assign bus.release_n = release_n_ff;
  assign data_take_out = take_ff;

endmodule

// ===== src/sysbus_if.sv
// Shared system bus between processor end and agent end.
// Undriven bus cycles read as all ones, standing in for pull-ups.
`timescale 1ns/1ps
interface sysbus_if;
  import sysbus_pkg::*;
  logic              ext_request_n;
  logic              release_n;
  logic              agent_valid_n;
  logic              cpu_valid_n;
  logic              cpu_oe_n;
  logic [CMD_W-1:0]  cpu_cmd;
  logic [AD_W-1:0]   cpu_ad;
  logic [ADC_W-1:0]  cpu_adc;
  logic              cpu_cmdp;
  logic              agent_oe_n;
  logic [CMD_W-1:0]  agent_cmd;
  logic [AD_W-1:0]   agent_ad;
  logic [ADC_W-1:0]  agent_adc;
  logic              agent_cmdp;
  logic [CMD_W-1:0]  command_bus;
  logic [AD_W-1:0]   addr_data_bus;
  logic [ADC_W-1:0]  addr_data_check_bus;
  logic              command_parity_bus;

  assign command_bus = !cpu_oe_n ? cpu_cmd : !agent_oe_n ? agent_cmd : '1;
  assign addr_data_bus = !cpu_oe_n ? cpu_ad : !agent_oe_n ? agent_ad : '1;
  assign addr_data_check_bus = !cpu_oe_n ? cpu_adc : !agent_oe_n ? agent_adc : '1;
  assign command_parity_bus = !cpu_oe_n ? cpu_cmdp : !agent_oe_n ? agent_cmdp : 1'b1;

  modport cpu_end (
    input  ext_request_n, agent_valid_n, command_bus, addr_data_bus,
           addr_data_check_bus, command_parity_bus,
    output release_n, cpu_valid_n, cpu_oe_n, cpu_cmd, cpu_ad, cpu_adc, cpu_cmdp
  );
  modport agent_end (
    input  release_n, cpu_valid_n, command_bus, addr_data_bus,
    output ext_request_n, agent_valid_n, agent_oe_n, agent_cmd, agent_ad,
           agent_adc, agent_cmdp
  );
endinterface

// ===== src/sysbus_pkg.sv
// Shared constants, encodings and helpers of the system bus link.
// Assumes one clock for both ends and one shared reset.
package sysbus_pkg;

  localparam int AD_W = 64;
  localparam int ADC_W = 8;
  localparam int CMD_W = 9;
  localparam int REG_AW = 36;

  // Register port map
  localparam logic [REG_AW-1:0] CFG_ADDR = 36'hF_FF10_0000;
  localparam logic [REG_AW-1:0] STAT_ADDR = 36'hF_FF10_0008;
  localparam logic [AD_W-1:0] CFG_RESET = 64'h0;
  localparam int CFG_FAST_BIT = 0;

  // Command bus fields
  localparam int KIND_BIT = 8;
  localparam int FINAL_BIT = 7;
  localparam int RESP_BIT = 6;
  localparam int ERR_BIT = 5;
  localparam int NOCHK_BIT = 4;
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_NULL = 3'h3;
  localparam logic [1:0] PROP_BLOCK = 2'h2;
  localparam logic [1:0] PROP_WORD = 2'h3;
  localparam logic [1:0] PROP_RELEASE = 2'h0;
  localparam logic [2:0] SIZE_WORD = 3'h3;
  localparam logic [2:0] SIZE_BLK8 = 3'h5;
  localparam logic [2:0] RSVD3 = 3'h7;

  // Beat counts and pacing
  localparam logic [3:0] BLOCK_BEATS = 4'h8;
  localparam logic [1:0] SLOW_GAP = 2'h2;

  function automatic logic [CMD_W-1:0] make_cmd(input logic [2:0] kind,
                                                input logic [1:0] prop,
                                                input logic [2:0] size);
    make_cmd = {1'b0, kind, prop, size};
  endfunction

  // Reserved identifier bits always sent as ones
  function automatic logic [CMD_W-1:0] make_id(input logic last, input logic resp,
                                               input logic err);
    make_id = {1'b1, ~last, ~resp, err, 1'b0, 4'hF};
  endfunction

  function automatic logic [ADC_W-1:0] check_bits(input logic [AD_W-1:0] ad);
    for (int i = 0; i < ADC_W; i++) begin
      check_bits[i] = ^ad[8*i +: 8];
    end
  endfunction

endpackage

// ===== tb/sysbus_monitor.sv
// Link checker: handover, strobes, encodings, command parity and check bit 7.
// Assumes resolved link signals on one clock.
`timescale 1ns/1ps
module sysbus_monitor
  import sysbus_pkg::*;
(
  // Clock and reset
  input wire logic             clock_in,
  input wire logic             srst_in,
  // Link
  input wire logic             ext_request_n,
  input wire logic             release_n,
  input wire logic             agent_valid_n,
  input wire logic             cpu_valid_n,
  input wire logic             cpu_oe_n,
  input wire logic             agent_oe_n,
  input wire logic [CMD_W-1:0] command_bus,
  input wire logic [AD_W-1:0]  addr_data_bus,
  input wire logic [ADC_W-1:0] addr_data_check_bus,
  input wire logic             command_parity_bus
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  logic wr_cmd_ff;
  // Write data cycles are not responses
  always_ff @(posedge clock_in) begin
    wr_cmd_ff <= !agent_valid_n && command_bus[8:5] == 4'h2;
  end
  ////////////////////////////////////////////////////////////
  rel_pulse_a: assert property ($fell(release_n) |=> release_n)
    else $error("release pulse too long");
  rel_latency_a: assert property ($fell(ext_request_n) |-> ##[1:24] !release_n)
    else $error("release latency out of range");
  req_drop_a: assert property ($fell(release_n) |-> ##2 $rose(ext_request_n))
    else $error("request not dropped");
  no_clash_a: assert property (cpu_oe_n || agent_oe_n)
    else $error("both ends drive");
  idle_turn_a: assert property ($rose(cpu_oe_n) || $rose(agent_oe_n) |->
    cpu_oe_n && agent_oe_n) else $error("no idle cycle at handover");
  ext_write_a: assert property (!agent_valid_n &&
    command_bus[8:5] == 4'h2 |-> (command_bus[4:0] == 5'h1B) ##1
    (!agent_valid_n && command_bus[8:7] == 2'h2)
    ##1 agent_oe_n) else $error("bad external write sequence");
  id_rsvd_a: assert property (!agent_valid_n && command_bus[8] |->
    command_bus[3:0] == 4'hF) else $error("identifier reserved bits");
  null_rsvd_a: assert property (!agent_valid_n && command_bus[8:5] == 4'h3 |->
    command_bus[4:0] == 5'h07) else $error("bad release null");
  resp_id_a: assert property (!agent_valid_n && command_bus[8] && !wr_cmd_ff |->
    !command_bus[6]) else $error("response not marked");
  check_bits_a: assert property (!(cpu_oe_n && agent_oe_n) |->
    command_parity_bus == ^command_bus && addr_data_check_bus[7] == ^addr_data_bus[63:56])
    else $error("check bits off");
  cpu_cmd_a: assert property (!cpu_valid_n && !command_bus[8] |->
    command_bus[7:5] == CMD_READ || command_bus[7:5] == CMD_WRITE)
    else $error("bad processor command");
  write_c: cover property (!agent_valid_n && command_bus[8:5] == 4'h2);
  release_c: cover property ($fell(release_n));
  beat_c: cover property (!cpu_valid_n && command_bus[8]);
endmodule

// ===== tb/testbench.sv
// Bench joining processor end and agent end over the link.
// Assumes the package constants; one clock for all.
`timescale 1ns/1ps
module testbench;
  import sysbus_pkg::*;
  logic              clock_in, srst_in, reg_wr_in, reg_rd_in, req_valid_in, req_write_in;
  logic              req_block_in, req_ready_out, data_take_out, resp_valid_out;
  logic              resp_last_out, bus_error_out, line_dirty_out, ext_wr_valid_out;
  logic              op_valid_in, op_indep_in, op_ready_out, op_done_out, rd_pend_out;
  logic              rd_block_out, resp_ready_out, resp_valid_in, resp_error_in;
  logic [REG_AW-1:0] reg_addr_in;
  logic [AD_W-1:0]   reg_wdata_in, reg_rdata_out, req_addr_in, req_data_in, resp_data_out;
  logic [AD_W-1:0]   ext_wr_addr_out, ext_wr_data_out, op_addr_in, op_data_in;
  logic [AD_W-1:0]   rd_addr_out, resp_data_in, wa, wd, rdq[$];
  logic [7:0]        op_len_in;
  int                n_mismatch, n_checks, cyc, nw, nerr, ndirty, nlast, ntake, bt[$];
  logic [AD_W-1:0]   rows[3][2] = '{'{64'h100, 64'h1234_5678}, '{64'h104, 64'hFFFF_FFFF},
                                   '{64'hFFC, 64'h0}};
  sysbus_if sb();
  sysbus_cpu_end u_sysbus_cpu_end (.*, .bus(sb));
  sysbus_agent_end u_sysbus_agent_end (.*, .bus(sb));
  sysbus_monitor u_sysbus_monitor (.clock_in, .srst_in, .ext_request_n(sb.ext_request_n),
    .release_n(sb.release_n), .agent_valid_n(sb.agent_valid_n),
    .cpu_valid_n(sb.cpu_valid_n), .cpu_oe_n(sb.cpu_oe_n), .agent_oe_n(sb.agent_oe_n),
    .command_bus(sb.command_bus), .addr_data_bus(sb.addr_data_bus),
    .addr_data_check_bus(sb.addr_data_check_bus),
    .command_parity_bus(sb.command_parity_bus));
  ////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (ext_wr_valid_out) begin
      nw++;
      wa = ext_wr_addr_out;
      wd = ext_wr_data_out;
    end
    if (resp_valid_out) rdq.push_back(resp_data_out);
    nerr += int'(bus_error_out);
    ndirty += int'(line_dirty_out);
    nlast += int'(resp_last_out);
    ntake += int'(data_take_out);
    if (!sb.cpu_valid_n && sb.command_bus[KIND_BIT]) bt.push_back(cyc);
    // Well beyond the longest sequence below
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic end_sim;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [AD_W-1:0] s, input logic [AD_W-1:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [REG_AW-1:0] a, input logic [AD_W-1:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [REG_AW-1:0] a, input logic [AD_W-1:0] e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    @(negedge clock_in);
    chk(reg_rdata_out, e);
  endtask
  task automatic op(input logic i, input logic [7:0] n, input logic [AD_W-1:0] a, d);
    @(posedge clock_in);
    op_indep_in <= i;
    op_len_in <= n;
    op_addr_in <= a;
    op_data_in <= d;
    op_valid_in <= 1'b1;
    do @(negedge clock_in); while (!op_ready_out);
    @(posedge clock_in);
    op_valid_in <= 1'b0;
    do @(negedge clock_in); while (!op_done_out);
    repeat (3) @(posedge clock_in);
  endtask
  task automatic rq(input logic w, input logic b);
    @(posedge clock_in);
    req_write_in <= w;
    req_block_in <= b;
    req_valid_in <= 1'b1;
    do @(negedge clock_in); while (!req_ready_out);
    @(posedge clock_in);
    req_valid_in <= 1'b0;
  endtask
  // Each beat is held until the edge that takes it
  task automatic rsp(input int n, input logic [7:0] em);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_in);
      resp_valid_in <= 1'b1;
      resp_data_in <= 64'hA0 + i;
      resp_error_in <= em[i];
      do @(negedge clock_in); while (!resp_ready_out);
    end
    @(posedge clock_in);
    resp_valid_in <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {reg_wr_in, reg_rd_in, req_valid_in, req_write_in, req_block_in} = '0;
    {op_valid_in, op_indep_in, resp_valid_in, resp_error_in, op_len_in} = '0;
    {reg_addr_in, reg_wdata_in, op_addr_in, op_data_in, resp_data_in} = '0;
    req_addr_in = 64'h200;
    req_data_in = 64'h5A;
    srst_in = 1'b1;
    repeat (10) @(posedge clock_in);
    srst_in <= 1'b0;
    rd(CFG_ADDR, 64'h0);
    wr(36'h40, 64'h1);
    rd(36'h40, 64'h0);
    foreach (rows[i]) begin
      op(1'b0, 8'h0, rows[i][0], rows[i][1]);
      chk(wa, rows[i][0]);
      chk(wd, rows[i][1]);
    end
    op(1'b1, 8'h4, 64'h0, 64'h0);
    chk(64'(nw), 64'h3);
    rq(1'b0, 1'b0);
    rsp(1, 8'h0);
    chk(64'(rdq.size()), 64'h1);
    chk(rdq[0], 64'hA0);
    chk(rd_addr_out, 64'h200);
    chk(64'(rd_pend_out), 64'h0);
    chk(64'(nlast), 64'h1);
    rdq.delete();
    rq(1'b0, 1'b1);
    rsp(8, 8'h24);
    chk(64'(rdq.size()), 64'h8);
    chk(rdq[7], 64'hA7);
    chk(64'(nerr), 64'h1);
    chk(64'(ndirty), 64'h1);
    chk(64'(rd_block_out), 64'h1);
    chk(64'(nlast), 64'h2);
    for (int f = 0; f < 2; f++) begin
      bt.delete();
      ntake = 0;
      rq(1'b1, 1'b1);
      do @(negedge clock_in); while (bt.size() < 8);
      chk(64'(bt[7] - bt[0]), f ? 64'h7 : 64'h15);
      chk(64'(ntake), 64'h8);
      wr(CFG_ADDR, 64'h1);
    end
    rd(CFG_ADDR, 64'h1);
    // Mid-run reset must bring the pacing bit back to zero
    @(posedge clock_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    srst_in <= 1'b0;
    rd(CFG_ADDR, 64'h0);
    end_sim();
  end
endmodule
